// ==== inc/dps_pkg.sv ====
// Purpose: shared constants and types for the dual pot serial port
// Assumes: one system clock at 20 MHz; serial pins sampled on it
// Notes:   frame is id byte, instruction byte, data byte
package dps_pkg;
	localparam int          CLK_HZ          = 20000000;
	localparam int          NV_WRITE_MS     = 10;
	localparam int          NV_WRITE_CYC    = CLK_HZ / 1000 * NV_WRITE_MS;
	localparam logic [3:0]  DEV_TYPE_ID     = 4'h5;
	localparam int          POT_COUNT       = 2;
	localparam int          SLOT_COUNT      = 4;
	localparam int          TAP_COUNT       = 256;
	localparam logic [7:0]  SLOT_RESET_VAL  = 8'h80;
	localparam logic [3:0]  OP_READ_WIPER   = 4'h9;
	localparam logic [3:0]  OP_WRITE_WIPER  = 4'ha;
	localparam logic [3:0]  OP_READ_SLOT    = 4'hb;
	localparam logic [3:0]  OP_WRITE_SLOT   = 4'hc;
	localparam logic [3:0]  OP_XFR_TO_WIPER = 4'hd;
	localparam logic [3:0]  OP_XFR_TO_SLOT  = 4'he;
	localparam logic [3:0]  OP_READ_STATUS  = 4'h5;
	localparam int          SCK_HALF_CYC    = 8;
	typedef enum logic [1:0] {
		DPS_PH_ID,
		DPS_PH_INSTR,
		DPS_PH_DATA,
		DPS_PH_IGNORE
	} dps_phase_type;
endpackage

// ==== inc/dps_if.sv ====
// Purpose: serial link joining host end and pot end
// Assumes: chip select, clock, input and pause are driven by the host
// Notes:   shared-line level resolved here from the output enable
`timescale 1ns/10ps
`default_nettype none
interface dps_if;
	logic cs_n;
	logic sck;
	logic sdi;
	logic hold_n;
	logic sdo_o;
	logic sdo_oe_n;
	logic sdo;
	assign sdo = sdo_oe_n ? 1'b1 : sdo_o;
	modport pot  (input cs_n, input sck, input sdi, input hold_n, output sdo_o, output sdo_oe_n);
	modport host (output cs_n, output sck, output sdi, output hold_n, input sdo);
endinterface
`default_nettype wire

// ==== rtl/dps_pot_end.sv ====
// Purpose: serial slave port of a dual digital potentiometer
// Assumes: serial pins asynchronous to clk_sys_i, two-stage synchronised
// Notes:   nonvolatile slots are registers; write time is counted
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - read data changes on falling clock
// - input bits sampled on rising clock
// - pause low while clock low suspends
// - pause high while clock low resumes
// - host keeps pause high if unused
// - slave address must match strap inputs
// - deselected: output released, standby unless writing
// - chip select low enters active mode
// - no operation before first select falling edge
// - 256 taps chosen by wiper register
// - four nonvolatile slots per pot
// - power-up copies default slot to wiper
// - exactly one tap switch on
// - write protect low refuses slot writes
// - slot write finishes within ten ms
// - write-active bit reflects running write
module dps_pot_end
	import dps_pkg::*;
#(
	parameter int NV_CYC = dps_pkg::NV_WRITE_CYC
) (
	input  wire logic          clk_sys_i,          // system clock
	input  wire logic          resetn_i,           // power-up reset, active low
	dps_if.pot                 bus,                // serial link
	input  wire logic          addr_strap_bit0_i,  // address strap 0
	input  wire logic          addr_strap_bit1_i,  // address strap 1
	input  wire logic [1:0]    addr_strap_hi_i,    // address straps 3..2
	input  wire logic          wp_n_i,             // write protect, active low
	output logic [255:0]       tap0_o,             // one-hot tap, pot 0
	output logic [255:0]       tap1_o,             // one-hot tap, pot 1
	output logic [7:0]         wiper0_o,           // wiper position, pot 0
	output logic [7:0]         wiper1_o,           // wiper position, pot 1
	output logic               nv_write_active_o,  // slot write running
	output logic               standby_o           // standby power mode
);
	import dps_pkg::*;

	typedef struct packed {
		logic [1:0]    cs_s, sck_s, sdi_s, hold_s;
		logic          sck_prev;
		logic          armed;
		logic          init_done;
		dps_phase_type phase;
		logic [2:0]    bit_cnt;
		logic [7:0]    shift;
		logic [7:0]    instr;
		logic [7:0]    out_sh;
		logic          out_en;
		logic          sdo;
		logic [1:0]    wp_s;
		logic [1:0][3:0] strap_s;
		logic [POT_COUNT-1:0][7:0]                 wiper_position_reg;
		logic [POT_COUNT-1:0][SLOT_COUNT-1:0][7:0] slot;
		logic [31:0]   nv_cnt;
		logic          nv_write_active;
	} dps_pot_state_type;

	dps_pot_state_type st_reg, st_next;
	logic cs_n, sck, sdi, hold_n, rise, fall, pot;
	logic       wp_n;
	logic [3:0] strap;
	logic [1:0] ra;
	logic [3:0] op;
	logic [7:0] rd_val;

	assign cs_n   = st_reg.cs_s[1];
	assign sck    = st_reg.sck_s[1];
	assign sdi    = st_reg.sdi_s[1];
	assign hold_n = st_reg.hold_s[1];
	// straps and write protect are pins too, so they pass the same two stages
	assign wp_n   = st_reg.wp_s[1];
	assign strap  = st_reg.strap_s[1];
	// pause freezes edge detection; the host only moves it with clock low
	assign rise   = hold_n & sck & ~st_reg.sck_prev;
	assign fall   = hold_n & ~sck & st_reg.sck_prev;
	assign op     = st_reg.instr[7:4];
	assign ra     = st_reg.instr[2:1];
	assign pot    = st_reg.instr[0];

	always_comb begin
		case (op)
			OP_READ_WIPER:  rd_val = st_reg.wiper_position_reg[pot];
			OP_READ_SLOT:   rd_val = st_reg.slot[pot][ra];
			OP_READ_STATUS: rd_val = {7'h00, st_reg.nv_write_active};
			default:        rd_val = 8'h00;
		endcase
	end

	always_comb begin
		logic [7:0] byte_in;
		logic       nv_start;
		byte_in  = {st_reg.shift[6:0], sdi};
		nv_start = 1'b0;
		st_next  = st_reg;
		st_next.cs_s   = {st_reg.cs_s[0], bus.cs_n};
		st_next.sck_s  = {st_reg.sck_s[0], bus.sck};
		st_next.sdi_s  = {st_reg.sdi_s[0], bus.sdi};
		st_next.hold_s = {st_reg.hold_s[0], bus.hold_n};
		st_next.wp_s   = {st_reg.wp_s[0], wp_n_i};
		st_next.strap_s = {st_reg.strap_s[0],
			{addr_strap_hi_i, addr_strap_bit1_i, addr_strap_bit0_i}};
		if (hold_n) begin
			st_next.sck_prev = sck;
		end
		if (cs_n) begin
			st_next.armed   = 1'b1;
			st_next.phase   = DPS_PH_ID;
			st_next.bit_cnt = 3'd0;
			st_next.out_en  = 1'b0;
		end else if (!st_reg.armed) begin
			st_next.phase = DPS_PH_IGNORE;
		end else if (rise) begin
			st_next.shift   = byte_in;
			st_next.bit_cnt = st_reg.bit_cnt + 3'd1;
			if (st_reg.bit_cnt == 3'd7) begin
				case (st_reg.phase)
					DPS_PH_ID: begin
						if (byte_in == {DEV_TYPE_ID, strap}) begin
							st_next.phase = DPS_PH_INSTR;
						end else begin
							st_next.phase = DPS_PH_IGNORE;
						end
					end
					DPS_PH_INSTR: begin
						st_next.instr = byte_in;
						st_next.phase = DPS_PH_DATA;
						case (byte_in[7:4])
							OP_XFR_TO_WIPER: st_next.wiper_position_reg[byte_in[0]] =
								st_reg.slot[byte_in[0]][byte_in[2:1]];
							OP_XFR_TO_SLOT: begin
								if (wp_n && !st_reg.nv_write_active) begin
									st_next.slot[byte_in[0]][byte_in[2:1]] =
										st_reg.wiper_position_reg[byte_in[0]];
									nv_start = 1'b1;
								end
							end
							default: ;
						endcase
					end
					DPS_PH_DATA: begin
						st_next.phase = DPS_PH_IGNORE;
						if (op == OP_WRITE_WIPER) begin
							st_next.wiper_position_reg[pot] = byte_in;
						end else if (op == OP_WRITE_SLOT && wp_n
								&& !st_reg.nv_write_active) begin
							st_next.slot[pot][ra] = byte_in;
							nv_start = 1'b1;
						end
					end
					default: st_next.phase = DPS_PH_IGNORE;
				endcase
			end
		end else if (fall && st_reg.phase == DPS_PH_DATA) begin
			if (st_reg.bit_cnt == 3'd0) begin
				st_next.out_sh = {rd_val[6:0], 1'b0};
				st_next.sdo    = rd_val[7];
				st_next.out_en = (op == OP_READ_WIPER) | (op == OP_READ_SLOT)
					| (op == OP_READ_STATUS);
			end else begin
				st_next.out_sh = {st_reg.out_sh[6:0], 1'b0};
				st_next.sdo    = st_reg.out_sh[7];
			end
		end
		if (!st_reg.init_done) begin
			st_next.init_done = 1'b1;
			for (int p = 0; p < POT_COUNT; p++) begin
				st_next.wiper_position_reg[p] = st_reg.slot[p][0];
			end
		end
		if (nv_start) begin
			st_next.nv_write_active = 1'b1;
			st_next.nv_cnt          = 32'(NV_CYC - 1);
		end else if (st_reg.nv_write_active) begin
			if (st_reg.nv_cnt == 32'd0) begin
				st_next.nv_write_active = 1'b0;
			end else begin
				st_next.nv_cnt = st_reg.nv_cnt - 32'd1;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_reg          <= '0;
			// select reads low until the pin has truly been high, so only a
			// real high-to-low on the pin can arm the port after power-up
			st_reg.cs_s     <= 2'b00;
			st_reg.hold_s   <= 2'b11;
			st_reg.phase    <= DPS_PH_IGNORE;
			st_reg.slot     <= {POT_COUNT * SLOT_COUNT{SLOT_RESET_VAL}};
		end else begin
			st_reg <= st_next;
		end
	end

	always_comb begin
		tap0_o = '0;
		tap1_o = '0;
		tap0_o[st_reg.wiper_position_reg[0]] = 1'b1;
		tap1_o[st_reg.wiper_position_reg[1]] = 1'b1;
	end

	assign wiper0_o          = st_reg.wiper_position_reg[0];
	assign wiper1_o          = st_reg.wiper_position_reg[1];
	assign nv_write_active_o = st_reg.nv_write_active;
	assign standby_o         = cs_n & ~st_reg.nv_write_active;
	assign bus.sdo_o         = st_reg.sdo;
	assign bus.sdo_oe_n      = ~(st_reg.out_en & ~cs_n);
endmodule
`default_nettype wire

// ==== rtl/dps_host_end.sv ====
// Purpose: host side master sending three-byte frames to the pot end
// Assumes: serial clock derived from clk_sys_i by an enable divider
// Notes:   pause request only acts while the serial clock is low
`timescale 1ns/10ps
`default_nettype none
module dps_host_end
	import dps_pkg::*;
(
	input  wire logic          clk_sys_i,   // system clock
	input  wire logic          resetn_i,    // reset, active low
	dps_if.host                bus,         // serial link
	input  wire logic          start_i,     // start frame, pulse
	input  wire logic [7:0]    id_i,        // identification byte
	input  wire logic [7:0]    instr_i,     // instruction byte
	input  wire logic [7:0]    data_i,      // data byte
	input  wire logic          pause_i,     // pause request, level
	output logic               busy_o,      // frame in progress
	output logic               done_o,      // frame finished, pulse
	output logic [7:0]         rdata_o      // last byte sampled back
);
	import dps_pkg::*;

	typedef struct packed {
		logic [1:0]  sdo_s;
		logic        busy, done, cs_n, sck, sdi, hold_n;
		logic [3:0]  div;
		logic [4:0]  bit_cnt;
		logic [23:0] tx;
		logic [7:0]  rx;
		logic        lead;
	} dps_host_state_type;

	dps_host_state_type st_reg, st_next;
	logic tick;

	assign tick = (st_reg.div == 4'(SCK_HALF_CYC - 1));

	always_comb begin
		st_next       = st_reg;
		st_next.done  = 1'b0;
		st_next.sdo_s = {st_reg.sdo_s[0], bus.sdo};
		st_next.div   = tick ? 4'h0 : st_reg.div + 4'h1;
		if (!st_reg.busy) begin
			st_next.cs_n = 1'b1;
			if (start_i) begin
				st_next.busy    = 1'b1;
				st_next.cs_n    = 1'b0;
				st_next.tx      = {id_i, instr_i, data_i};
				st_next.bit_cnt = 5'd0;
				st_next.lead    = 1'b1;
				st_next.div     = 4'h0;
			end
		end else if (tick) begin
			if (!st_reg.sck) begin
				// pause line only toggles while the clock rests low
				st_next.hold_n = ~pause_i;
			end
			if (!st_reg.sck && st_reg.hold_n && !pause_i) begin
				if (st_reg.lead) begin
					st_next.sdi  = st_reg.tx[23];
					st_next.lead = 1'b0;
				end else if (st_reg.bit_cnt == 5'd24) begin
					st_next.busy = 1'b0;
					st_next.cs_n = 1'b1;
					st_next.done = 1'b1;
				end else begin
					st_next.sck = 1'b1;
					st_next.rx  = {st_reg.rx[6:0], st_reg.sdo_s[1]};
				end
			end else if (st_reg.sck) begin
				st_next.sck     = 1'b0;
				st_next.bit_cnt = st_reg.bit_cnt + 5'd1;
				st_next.tx      = {st_reg.tx[22:0], 1'b0};
				st_next.sdi     = st_reg.tx[22];
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_reg        <= '0;
			st_reg.cs_n   <= 1'b1;
			st_reg.hold_n <= 1'b1;
			st_reg.sdo_s  <= 2'b11;
		end else begin
			st_reg <= st_next;
		end
	end

	assign bus.cs_n   = st_reg.cs_n;
	assign bus.sck    = st_reg.sck;
	assign bus.sdi    = st_reg.sdi;
	assign bus.hold_n = st_reg.hold_n;
	assign busy_o     = st_reg.busy;
	assign done_o     = st_reg.done;
	assign rdata_o    = st_reg.rx;
endmodule
`default_nettype wire

// ==== bench/dps_chk.sv ====
// Purpose: link checks between host end and pot end
// Assumes: one clock; every link line is registered on it
// Notes:   five-cycle windows cover the pot's input synchroniser
`timescale 1ns/10ps
`default_nettype none
module dps_chk #(
	parameter int NV_CYC = 2000
) (
	input wire logic clk_sys_i,         // clock
	input wire logic resetn_i,          // reset, low
	input wire logic cs_n,              // select
	input wire logic sck,               // serial clock
	input wire logic sdi,               // serial in
	input wire logic hold_n,            // pause
	input wire logic sdo_o,             // pot data
	input wire logic sdo_oe_n,          // pot enable
	input wire logic nv_write_active_o, // slot write
	input wire logic standby_o          // standby
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	logic [5:0] rises;
	logic       sck_q;
	int         nv_cnt;
	// rise count restarts while deselected, so a short frame cannot hide
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rises <= 6'h00;
			sck_q <= 1'b0;
			nv_cnt <= 0;
		end else begin
			sck_q <= sck;
			nv_cnt <= nv_write_active_o ? nv_cnt + 1 : 0;
			rises <= cs_n ? 6'h00 : rises + 6'(sck && !sck_q);
		end
	end
	sequence s_desel;
		cs_n [*5];
	endsequence
	sequence s_sel;
		!cs_n [*5];
	endsequence
	a_sdo_released:
	assert property (s_desel |-> sdo_oe_n) else $error("sdo driven while deselected");
	a_standby_mode:
	assert property (s_desel |-> standby_o == !nv_write_active_o) else $error("standby wrong");
	a_active_mode:
	assert property (s_sel |-> !standby_o) else $error("standby while selected");
	a_sdo_on_fall:
	assert property (!sdo_oe_n && !$past(sdo_oe_n) && $changed(sdo_o) |-> !sck)
		else $error("sdo moved while clock high");
	a_sdi_settled:
	assert property (sck |-> $stable(sdi)) else $error("sdi moved while clock high");
	a_pause_edges:
	assert property ($changed(hold_n) |-> !sck && !$past(sck)) else $error("pause moved, clock high");
	a_pause_holds:
	assert property (!hold_n && !$past(hold_n) |-> $stable(sck)) else $error("clock ran in pause");
	a_frame_bits:
	assert property ($rose(cs_n) |-> rises == 6'h18) else $error("frame not 24 bits");
	a_nv_bounded:
	assert property (nv_cnt <= NV_CYC) else $error("slot write too long");
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// Purpose: self-checking bench, host end driving pot end
// Assumes: pause_i high requests a pause; a released sdo reads ones
// Notes:   slot write time shortened through NV_CYC
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
	import dps_pkg::*;
	localparam int NV = 2000;
	logic         clk_sys_i = 1'b0;
	logic         resetn_i = 1'b0;
	logic         start = 1'b0;
	logic         pause = 1'b0;
	logic         wp_n = 1'b1;
	logic         busy, done, nv, sb;
	logic [7:0]   id = 8'h00, instr = 8'h00, data = 8'h00;
	logic [7:0]   rdata, w0, w1, v, s, idb;
	logic [7:0]   wv [2];
	logic [3:0]   st = 4'h0;
	logic [255:0] t0, t1;
	logic [7:0]   exp_q [$];
	logic [7:0]   msk_q [$];
	int           n_errors = 0, total_checks = 0, cyc = 0, n;
	always #25 clk_sys_i = ~clk_sys_i;
	dps_if lnk ();
	dps_pot_end #(.NV_CYC(NV)) i_dps_pot_end (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
		.bus(lnk), .addr_strap_bit0_i(st[0]), .addr_strap_bit1_i(st[1]), .addr_strap_hi_i(st[3:2]),
		.wp_n_i(wp_n), .tap0_o(t0), .tap1_o(t1), .wiper0_o(w0), .wiper1_o(w1),
		.nv_write_active_o(nv), .standby_o(sb));
	dps_host_end i_dps_host_end (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .bus(lnk),
		.start_i(start), .id_i(id), .instr_i(instr), .data_i(data), .pause_i(pause),
		.busy_o(busy), .done_o(done), .rdata_o(rdata));
	dps_chk #(.NV_CYC(NV)) i_dps_chk (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
		.cs_n(lnk.cs_n), .sck(lnk.sck), .sdi(lnk.sdi), .hold_n(lnk.hold_n), .sdo_o(lnk.sdo_o),
		.sdo_oe_n(lnk.sdo_oe_n), .nv_write_active_o(nv), .standby_o(sb));
	task automatic report_and_stop();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	function automatic logic [7:0] ins(input logic [3:0] op, input logic [1:0] ra, input logic p);
		return {op, 1'b0, ra, p};
	endfunction
	// the expected reply is queued before the frame; non-read frames expect ones
	task automatic frame(input logic [7:0] i, c, d, e, m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		@(posedge clk_sys_i) #2 {start, id, instr, data} = {1'b1, i, c, d};
		@(posedge clk_sys_i) #2 start = 1'b0;
		n = 0;
		do begin
			@(posedge clk_sys_i) #2 n++;
		end while (done !== 1'b1 && n < 3000);
		if (done !== 1'b1) n_errors++;
	endtask
	task automatic wait_nv();
		n = 0;
		while (nv !== 1'b0 && n < 5000) begin
			@(posedge clk_sys_i) #2 n++;
		end
		if (nv !== 1'b0) n_errors++;
	endtask
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (done === 1'b1) begin
			`CHK(rdata & msk_q[0], exp_q[0] & msk_q[0])
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
		if (cyc == 40000) begin
			n_errors++;
			report_and_stop();
		end
	end
	initial begin
		void'($urandom(43));
		st = 4'($urandom);
		idb = {DEV_TYPE_ID, st};
		repeat (12) @(posedge clk_sys_i);
		#2 resetn_i = 1'b1;
		repeat (3) @(posedge clk_sys_i);
		#2;
		`CHK(w0, SLOT_RESET_VAL)
		`CHK(w1, SLOT_RESET_VAL)
		`CHK(sb, 1'b1)
		`CHK(busy, 1'b0)
		for (int p = 0; p < 2; p++) begin
			wv[p] = 8'($urandom);
			frame(idb, ins(OP_WRITE_WIPER, 2'h0, p[0]), wv[p], 8'hff, 8'hff);
			`CHK(p ? w1 : w0, wv[p])
			`CHK(p ? t1 : t0, 256'h1 << wv[p])
			frame(idb, ins(OP_READ_WIPER, 2'h0, p[0]), 8'h00, wv[p], 8'hff);
		end
		for (int k = 0; k < 2; k++) begin
			frame(idb ^ (k ? 8'h10 : 8'h01), ins(OP_WRITE_WIPER, 2'h0, 1'b0), ~wv[0], 8'hff, 8'hff);
			`CHK(w0, wv[0])
		end
		// pause lands inside the returned byte, where a lost bit would show
		fork
			frame(idb, ins(OP_READ_WIPER, 2'h0, 1'b1), 8'h00, wv[1], 8'hff);
			begin
				repeat (300) @(posedge clk_sys_i);
				#2 pause = 1'b1;
				repeat (60) @(posedge clk_sys_i);
				#2 pause = 1'b0;
			end
		join
		s = 8'($urandom);
		wp_n = 1'b0;
		frame(idb, ins(OP_WRITE_SLOT, 2'h1, 1'b0), s, 8'hff, 8'hff);
		`CHK(nv, 1'b0)
		wp_n = 1'b1;
		frame(idb, ins(OP_READ_SLOT, 2'h1, 1'b0), 8'h00, SLOT_RESET_VAL, 8'hff);
		frame(idb, ins(OP_WRITE_SLOT, 2'h2, 1'b0), s, 8'hff, 8'hff);
		frame(idb, ins(OP_READ_STATUS, 2'h0, 1'b0), 8'h00, 8'h01, 8'h01);
		frame(idb, ins(OP_WRITE_SLOT, 2'h3, 1'b0), ~s, 8'hff, 8'hff);
		wait_nv();
		`CHK(nv, 1'b0)
		frame(idb, ins(OP_READ_STATUS, 2'h0, 1'b0), 8'h00, 8'h00, 8'h01);
		frame(idb, ins(OP_READ_SLOT, 2'h2, 1'b0), 8'h00, s, 8'hff);
		frame(idb, ins(OP_READ_SLOT, 2'h3, 1'b0), 8'h00, SLOT_RESET_VAL, 8'hff);
		frame(idb, ins(OP_XFR_TO_WIPER, 2'h2, 1'b0), 8'h00, 8'hff, 8'hff);
		`CHK(w0, s)
		frame(idb, ins(OP_XFR_TO_SLOT, 2'h0, 1'b1), 8'h00, 8'hff, 8'hff);
		wait_nv();
		frame(idb, ins(OP_READ_SLOT, 2'h0, 1'b1), 8'h00, wv[1], 8'hff);
		repeat (3) @(posedge clk_sys_i);
		report_and_stop();
	end
endmodule
`default_nettype wire
